// >>> hdl/cbr_repeater.sv
module cbr_repeater
#(
  parameter int DOM_TICKS = cbr_pkg::DOM_TIMEOUT_TICKS,
  parameter int HOLD_TICKS = cbr_pkg::SUPPRESS_TICKS
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Digital and comparator inputs
  input wire cbr_pkg::cbr_pins_t pins,
  // Bus drivers, high means drive dominant
  output logic bus_one_drive,
  output logic bus_two_drive,
  // Controller receive output
  output logic controller_receive_out,
  // Expansion receive output with enable
  output logic expansion_receive_out,
  output logic expansion_receive_oe
);
  import cbr_pkg::*;

  localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_TICKS);

  cbr_state_t st;
  cbr_state_t next_st;
  logic [3:0] path_in;
  logic [3:0] t_dom;
  logic [1:0] supp;
  logic [1:0] rx_eff;
  logic [1:0] bus_req;
  logic ctrl_low;
  logic exp_low;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Low pin level means dominant
  function automatic logic is_dom(input logic level);
    return level == 1'b0;
  endfunction

  function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] c, input logic t);
    return (t && c != CNT_RESET) ? c - 16'h0001 : c;
  endfunction

  // ------------------------------------------------------------
  // Receiver gating and timer inputs
  // ------------------------------------------------------------
  always_comb
  begin
    path_in[PATH_CTRL] = is_dom(st.sync.controller_transmit_in);
    path_in[PATH_EXP] = is_dom(st.sync.expansion_transmit_in);
    // Disabled receiver is forced recessive, else passed as is
    path_in[PATH_BUS_ONE] = !st.sync.bus_one_disable && is_dom(st.sync.bus_one_rx);
    path_in[PATH_BUS_TWO] = !st.sync.bus_two_disable && is_dom(st.sync.bus_two_rx);
  end

  // ------------------------------------------------------------
  // Dominant timers
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_timer
      cbr_dom_timer #(.LIMIT(DOM_TICKS)) u_timer
      (
        .clock(clock),
        .reset_n(reset_n),
        .tick(st.tick),
        .dom_in(path_in[gi]),
        .dom_out(t_dom[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Routing
  // ------------------------------------------------------------
  always_comb
  begin
    // Own drive echoes back; mask it and a short tail after it
    supp[0] = st.drive[0] || st.hold[0] != CNT_RESET;
    supp[1] = st.drive[1] || st.hold[1] != CNT_RESET;
    rx_eff[0] = t_dom[PATH_BUS_ONE] && !supp[0];
    rx_eff[1] = t_dom[PATH_BUS_TWO] && !supp[1];
    // Same equation for both buses, no priority
    bus_req[0] = t_dom[PATH_CTRL] || t_dom[PATH_EXP] || rx_eff[1];
    bus_req[1] = t_dom[PATH_CTRL] || t_dom[PATH_EXP] || rx_eff[0];
    ctrl_low = t_dom[PATH_CTRL] || t_dom[PATH_EXP] || rx_eff[0] || rx_eff[1];
    // Expansion input does not loop back to the expansion output
    exp_low = t_dom[PATH_CTRL] || rx_eff[0] || rx_eff[1];
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // Two stages before anything looks at a pin
    next_st.meta = pins;
    next_st.sync = st.meta;
    // Internal oscillator as a tick divider
    if (st.div == OSC_DIV_LAST)
    begin
      next_st.div = DIV_RESET;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.div = st.div + 8'h01;
      next_st.tick = 1'b0;
    end
    // Driver on only for dominant, enabled and cool
    next_st.drive[0] = bus_req[0] && !st.sync.bus_one_disable && !st.sync.over_temp;
    next_st.drive[1] = bus_req[1] && !st.sync.bus_two_disable && !st.sync.over_temp;
    // Release delay restarts each time drive ends
    for (int b = 0; b < 2; b++)
    begin
      if (st.drive[b])
        next_st.hold[b] = HOLD_LOAD;
      else
        next_st.hold[b] = count_down(st.hold[b], st.tick);
    end
    // Receive outputs keep working while too hot
    next_st.rx0 = !ctrl_low;
    next_st.rint = !exp_low;
    next_st.rint_oe = 1'b1;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      // Synchronisers reset to the idle levels, pins pulled up and over_temp low
      st.meta <= PINS_RESET;
      st.sync <= PINS_RESET;
      st.div <= DIV_RESET;
      st.tick <= 1'b0;
      st.drive <= 2'h0;
      st.hold <= '0;
      st.rx0 <= 1'b1;
      st.rint <= 1'b1;
      st.rint_oe <= 1'b0;
    end
    else
      st <= next_st;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus_one_drive = st.drive[0];
  assign bus_two_drive = st.drive[1];
  assign controller_receive_out = st.rx0;
  assign expansion_receive_out = st.rint;
  assign expansion_receive_oe = st.rint_oe;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence drive_ended_s(b);
    !st.drive[b] && $past(st.drive[b]);
  endsequence

  sequence masked_two_s(b);
    supp[b] ##1 supp[b];
  endsequence

  disable_rec_a: assert property (@(posedge clock) disable iff (!reset_n)
    (st.sync.bus_one_disable || st.sync.bus_two_disable) |=>
      !((bus_one_drive && $past(st.sync.bus_one_disable)) || (bus_two_drive && $past(st.sync.bus_two_disable))))
    else $error("disabled bus was driven");

  rx_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
    st.sync.bus_one_disable |=> !t_dom[PATH_BUS_ONE])
    else $error("disabled receiver reached routing");

  ctrl_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    (t_dom[PATH_CTRL] && !st.sync.bus_one_disable && !st.sync.over_temp) |=>
      (bus_one_drive && !controller_receive_out && !expansion_receive_out))
    else $error("controller dominant not routed");

  exp_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    (t_dom[PATH_EXP] && !t_dom[PATH_CTRL] && rx_eff == 2'h0) |=>
      (!controller_receive_out && expansion_receive_out))
    else $error("expansion dominant misrouted");

  idle_rec_a: assert property (@(posedge clock) disable iff (!reset_n)
    (t_dom[1:0] == 2'h0 && rx_eff == 2'h0) |=>
      (!bus_one_drive && !bus_two_drive && controller_receive_out && expansion_receive_out))
    else $error("idle inputs left a dominant");

  repeat_a: assert property (@(posedge clock) disable iff (!reset_n)
    (rx_eff[0] && !st.sync.bus_two_disable && !st.sync.over_temp) |=>
      (bus_two_drive && !controller_receive_out && !expansion_receive_out))
    else $error("bus one dominant not repeated");

  own_mask_a: assert property (@(posedge clock) disable iff (!reset_n)
    (bus_one_drive || bus_two_drive) |-> !((bus_one_drive && rx_eff[0]) || (bus_two_drive && rx_eff[1])))
    else $error("own drive fed back");

  release_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    drive_ended_s(0) |-> masked_two_s(0))
    else $error("reception resumed without delay");

  thermal_off_a: assert property (@(posedge clock) disable iff (!reset_n)
    (st.sync.over_temp && t_dom[PATH_CTRL]) |=>
      (!bus_one_drive && !bus_two_drive && !controller_receive_out))
    else $error("thermal shutdown wrong");

  reset_pins_a: assert property (@(posedge clock)
    !reset_n |=> (controller_receive_out && !expansion_receive_oe && !bus_one_drive && !bus_two_drive))
    else $error("outputs wrong during reset");

  reset_osc_a: assert property (@(posedge clock)
    !reset_n |=> (!st.tick && st.div == DIV_RESET))
    else $error("oscillator ran in reset");

endmodule // cbr_repeater

// >>> hdl/cbr_pkg.sv
package cbr_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int OSC_PERIOD_NS = 40;
  localparam int OSC_DIV_CYCLES = (OSC_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [7:0] OSC_DIV_LAST = 8'(OSC_DIV_CYCLES - 1);
  localparam int DOM_TIMEOUT_TICKS = 2500;
  localparam int SUPPRESS_TICKS = 4;
  localparam int CNT_W = 16;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic PIN_IDLE = 1'b1;
  localparam logic OT_IDLE = 1'b0;

  // ------------------------------------------------------------
  // Timer path indices
  // ------------------------------------------------------------
  localparam int PATH_CTRL = 0;
  localparam int PATH_EXP = 1;
  localparam int PATH_BUS_ONE = 2;
  localparam int PATH_BUS_TWO = 3;

  // Pins: low means dominant or enabled, over_temp high means hot
  typedef struct packed {
    logic controller_transmit_in;
    logic expansion_transmit_in;
    logic bus_two_disable;
    logic bus_one_disable;
    logic bus_two_rx;
    logic bus_one_rx;
    logic over_temp;
  } cbr_pins_t;

  localparam cbr_pins_t PINS_RESET = '{PIN_IDLE, PIN_IDLE, PIN_IDLE, PIN_IDLE, PIN_IDLE, PIN_IDLE, OT_IDLE};

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic dom_out;
  } cbr_timer_state_t;

  typedef struct packed {
    cbr_pins_t meta;
    cbr_pins_t sync;
    logic [7:0] div;
    logic tick;
    logic [1:0] drive;
    logic [1:0][CNT_W-1:0] hold;
    logic rx0;
    logic rint;
    logic rint_oe;
  } cbr_state_t;

endpackage

// >>> hdl/cbr_dom_timer.sv
module cbr_dom_timer
#(
  parameter int LIMIT = cbr_pkg::DOM_TIMEOUT_TICKS
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Oscillator tick and path
  input wire logic tick,
  input wire logic dom_in,
  output logic dom_out
);
  import cbr_pkg::*;

  localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);

  cbr_timer_state_t st;
  cbr_timer_state_t next_st;

  // ------------------------------------------------------------
  // Dominant time-out
  // ------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (!dom_in)
      next_st.cnt = CNT_RESET;
    else if (tick && st.cnt < LIM)
      next_st.cnt = st.cnt + 16'h0001;
    // Stuck dominant turns recessive until the input releases
    next_st.dom_out = dom_in && (next_st.cnt < LIM);
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      st.cnt <= CNT_RESET;
      st.dom_out <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign dom_out = st.dom_out;

  timeout_hit_a: assert property (@(posedge clock) disable iff (!reset_n)
    (dom_in && tick && st.cnt == LIM - 16'h0001) |=> !dom_out)
    else $error("timer output stayed dominant past the limit");

endmodule // cbr_dom_timer

// >>> verification/cbr_bus_model.sv
module cbr_bus_model
(
  // Device driver and other nodes
  input wire logic drive,
  input wire logic ext_dom,
  // Comparator result, low means dominant
  output logic rx
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Wired bus
  // ----------------------------------------
  // Own driver echoes straight back, so the device must mask it
  assign rx = !(drive || ext_dom);
endmodule // cbr_bus_model

// >>> verification/tb_cbr_repeater.sv
module tb_cbr_repeater;
  timeunit 1ns;
  timeprecision 1ps;
  import cbr_pkg::*;
  localparam int DOM = 20;
  localparam int HOLD = 2;
  logic clock, reset_n, tx0, text, en1, en2, hot, ext1, ext2;
  logic d1, d2, r0, ri, oe;
  wire logic rx1, rx2;
  cbr_pins_t pins;
  int failures, total_checks;
  assign pins = '{tx0, text, en2, en1, rx2, rx1, hot};
  cbr_repeater #(.DOM_TICKS(DOM), .HOLD_TICKS(HOLD)) i_cbr_repeater (.clock(clock), .reset_n(reset_n),
    .pins(pins), .bus_one_drive(d1), .bus_two_drive(d2), .controller_receive_out(r0),
    .expansion_receive_out(ri), .expansion_receive_oe(oe));
  cbr_bus_model i_cbr_bus_model_one (.drive(d1), .ext_dom(ext1), .rx(rx1));
  cbr_bus_model i_cbr_bus_model_two (.drive(d2), .ext_dom(ext2), .rx(rx2));
  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic give_verdict();
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(string what, logic seen, logic exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %b, seen %b", what, exp, seen);
    end
  endtask
  // Controller side keeps low as dominant
  task automatic drive_pins(logic t0, logic te, logic e1, logic e2, logic x1, logic x2, logic h);
    @(posedge clock);
    tx0 <= t0;
    text <= te;
    en1 <= e1;
    en2 <= e2;
    ext1 <= x1;
    ext2 <= x2;
    hot <= h;
  endtask
  // Bounded wait for the levels, then judge each one
  task automatic expect_outs(logic e1d, logic e2d, logic e0, logic ei);
    int n;
    n = 0;
    while (n < 40 && {d1, d2, r0, ri, oe} !== {e1d, e2d, e0, ei, 1'b1})
    begin
      @(negedge clock);
      n++;
    end
    check("bus_one_drive", d1, e1d);
    check("bus_two_drive", d2, e2d);
    check("controller_receive_out", r0, e0);
    check("expansion_receive_out", ri, ei);
    check("expansion_receive_oe", oe, 1'b1);
    if (n == 40) give_verdict();
  endtask
  // Return to idle and let suppression release, a fixed hold in ticks
  task automatic idle();
    drive_pins(1, 1, 0, 0, 0, 0, 0);
    expect_outs(0, 0, 1, 1);
    repeat ((HOLD + 2) * 10) @(posedge clock);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_check();
    @(posedge clock);
    reset_n <= 1'b0;
    drive_pins(0, 0, 0, 0, 1, 1, 0);
    repeat (3) @(negedge clock);
    check("reset bus_one_drive", d1, 1'b0);
    check("reset bus_two_drive", d2, 1'b0);
    check("reset controller_receive_out", r0, 1'b1);
    check("reset expansion_receive_oe", oe, 1'b0);
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    idle();
  endtask
  task automatic table_check();
    logic t0, te, e1, e2, dom;
    for (int i = 0; i < 16; i++)
    begin
      {e1, e2, t0, te} = 4'(i);
      dom = !t0 || !te;
      drive_pins(t0, te, e1, e2, 0, 0, 0);
      expect_outs(dom && !e1, dom && !e2, !dom, t0);
      idle();
    end
  endtask
  task automatic repeat_check();
    logic e1, e2, src, on;
    for (int i = 0; i < 8; i++)
    begin
      {e1, e2, src} = 3'(i);
      on = src ? !e2 : !e1;
      drive_pins(1, 1, e1, e2, !src, src, 0);
      expect_outs(src && on && !e1, !src && on && !e2, !on, !on);
      idle();
    end
  endtask
  task automatic release_check();
    drive_pins(0, 1, 0, 1, 0, 0, 0);
    expect_outs(1, 0, 0, 0);
    drive_pins(1, 1, 0, 1, 1, 0, 0);
    repeat (8) @(negedge clock);
    check("masked controller_receive_out", r0, 1'b1);
    expect_outs(0, 0, 0, 0);
    idle();
  endtask
  task automatic timeout_check();
    drive_pins(0, 1, 0, 0, 0, 0, 0);
    repeat (DOM * 5) @(negedge clock);
    check("early bus_one_drive", d1, 1'b1);
    repeat (DOM * 8) @(negedge clock);
    expect_outs(0, 0, 1, 1);
    idle();
  endtask
  task automatic hot_check();
    drive_pins(0, 1, 0, 0, 0, 0, 1);
    expect_outs(0, 0, 0, 0);
    drive_pins(1, 1, 0, 0, 1, 0, 1);
    expect_outs(0, 0, 0, 0);
    idle();
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    failures = 0;
    total_checks = 0;
    reset_n = 1'b0;
    {tx0, text, en1, en2, ext1, ext2, hot} = 7'h00;
    reset_check();
    table_check();
    repeat_check();
    release_check();
    timeout_check();
    hot_check();
    reset_check();
    give_verdict();
  end
endmodule // tb_cbr_repeater
